// ---- include/rke_prov_pkg.sv ----
// Constants, types and layouts shared by the provisioning and key-derivation block.
// Assumes a single 100 MHz clock and a synchronous active-low reset in the user.
// Overview of operation
// - Config bit 0 picks decrypt or XOR
// - Config bit 2 enables seed-based learning
// - Config bit 3 permits low-power sleep
// - Clock low, then high 8-128 ms enters programming
// - Programming message: key, config, checksum, 80 bits
// - Good checksum: store key, config, then acknowledge
// - Key programming triggers automatic erase-all
// - Ten bytes must sum to zero modulo 256
// - Erase-all installs serial-zero test transmitter
// - Learning a transmitter removes test transmitter
// - Serial number zero is never learned
// - Upper seed gives upper key half
// - Serial encoders: seeds are 6h/2h plus serial
// - 32-bit seed: upper seed is serial low bits
// - 48-bit seed: upper seed merges seed, serial
// - 60-bit seed: upper seed is seed top
// - Decrypt scheme: whole manufacturer key decrypts each seed
// - XOR scheme: seeds XOR manufacturer key halves
// - Brief learn request stops success indication
// - Success toggles learn indicator four seconds
// - Erase-all clears all four slots
package rke_prov_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_MS     = 1000000;
  localparam int MS_TICK_CYC   = NS_PER_MS / CLK_PERIOD_NS;

  localparam logic [7:0]  T_SETUP_MIN_MS = 8'h01;
  localparam logic [7:0]  T_SETUP_MAX_MS = 8'h40;
  localparam logic [7:0]  T_HOLD_MIN_MS  = 8'h08;
  localparam logic [7:0]  T_HOLD_MAX_MS  = 8'h80;
  localparam logic [7:0]  T_ACK_MS       = 8'h02;
  localparam logic [11:0] T_LEARN_IND_MS = 12'hFA0;
  localparam logic [11:0] T_TOGGLE_MS    = 12'h0FA;

  localparam int MSG_BITS       = 80;
  localparam int CFG_LSB        = 64;
  localparam int CSUM_LSB       = 72;
  localparam int NUM_SLOTS      = 4;
  localparam int CFG_SCHEME_BIT = 0;
  localparam int CFG_SEED_BIT   = 2;
  localparam int CFG_SLEEP_BIT  = 3;

  localparam logic [6:0]  BIT_LAST       = 7'h4F;
  localparam logic [9:0]  DEC_LAST_ROUND = 10'h20F;
  localparam logic [5:0]  DEC_KEY_START  = 6'h0F;
  localparam logic [31:0] NLF_TABLE      = 32'h3A5C742E;
  localparam logic [3:0]  SRC_HI_NIBBLE  = 4'h6;
  localparam logic [3:0]  SRC_LO_NIBBLE  = 4'h2;
  localparam logic [7:0]  CFG_RESET      = 8'h00;
  localparam logic [63:0] MAN_KEY_RESET  = 64'h0;

  typedef enum logic [1:0] {
    ENC_SERIAL28 = 2'h0,
    ENC_SEED32   = 2'h1,
    ENC_SEED48   = 2'h2,
    ENC_SEED60   = 2'h3
  } enc_type_e;

  typedef struct packed {
    enc_type_e   enc;
    logic [31:0] serial;
    logic [59:0] seed;
  } learn_req_s;

  typedef struct packed {
    logic [63:0] man_key;
    logic [7:0]  cfg;
  } prov_s;

  typedef struct packed {
    logic [31:0] hi;
    logic [31:0] lo;
  } seed_pair_s;

endpackage

// ---- hdl/rke_provision_keygen.sv ----
// Provisioning loader, slot bookkeeping and crypt key derivation of the decoder.
// Assumes prog_clk_in, prog_data_in and learn_request_n come from pins (synchronised
// here) and that learn_req/learn_info come from the decoder logic on clk.
`timescale 1ns/1ps
`default_nettype none
module rke_provision_keygen
  import rke_prov_pkg::*;
#(
  parameter int MS_CYC = MS_TICK_CYC                      // Cycles per millisecond tick.
) (
  input  wire logic        clk,                           // 100 MHz clock.
  input  wire logic        rst_n,                         // Synchronous reset, power-up.
  input  wire logic        prog_clk_in,                   // Programming clock pin.
  input  wire logic        prog_data_in,                  // Programming data pin, input side.
  output logic             prog_data_out,                 // Programming data pin, output level.
  output logic             prog_data_oe_n,                // Programming data pin enable, low drives.
  output logic             prog_mode,                     // Programming message being received.
  output logic             prog_ok,                       // One-cycle pulse, message stored.
  output logic             prog_bad,                      // One-cycle pulse, checksum failed.
  output logic             keygen_scheme_select,          // Stored scheme, 1 selects XOR.
  output logic             seed_learn_enable,             // Stored secure-learning enable.
  output logic             sleep_enable,                  // Sleep may be entered.
  input  wire logic        learn_req,                     // Pulse: learn a transmitter.
  input  wire learn_req_s  learn_info,                    // Encoder type, serial and seed.
  input  wire logic        learn_request_n,               // Learn button pin, active low.
  output logic             learn_done,                    // Pulse: learn finished (ok or failed).
  output logic             learn_fail,                    // Level with learn_done: refused.
  output logic             learn_indicator,               // Success indicator output.
  output logic [63:0]      crypt_key,                     // Last derived crypt key.
  output logic [NUM_SLOTS-1:0] slot_valid,                // Learned slots in use.
  output logic             test_tx_present                // Serial-zero test transmitter active.
);

  typedef enum logic [2:0] {
    P_POR  = 3'b000,
    P_HIGH = 3'b001,
    P_RECV = 3'b011,
    P_CHK  = 3'b010,
    P_ACK  = 3'b110,
    P_RUN  = 3'b111
  } prog_e;

  typedef enum logic [1:0] {
    L_IDLE = 2'b00,
    L_HI   = 2'b01,
    L_LO   = 2'b11,
    L_STOR = 2'b10
  } learn_e;

  // Sum of the ten message bytes, carries discarded.
  function automatic logic [7:0] byte_sum(input logic [MSG_BITS-1:0] m);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < MSG_BITS / 8; i++) begin
      s = s + m[i*8 +: 8];
    end
    return s;
  endfunction

  // Non-linear feedback lookup of the block cipher.
  function automatic logic nlf(input logic [31:0] y);
    return NLF_TABLE[{y[30], y[25], y[19], y[8], y[0]}];
  endfunction

  // One decryption round.
  function automatic logic [31:0] dec_round(input logic [31:0] y, input logic kb);
    return {y[30:0], y[31] ^ y[15] ^ kb ^ nlf(y)};
  endfunction

  // Pin synchronisers; the first stages feed only the second stages.
  logic [2:0] pclk_q;
  logic [1:0] pdat_q;
  logic [2:0] lreq_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pclk_q <= 3'h0;
      pdat_q <= 2'h0;
      lreq_q <= 3'h7;
    end else begin
      pclk_q <= {pclk_q[1:0], prog_clk_in};
      pdat_q <= {pdat_q[0], prog_data_in};
      lreq_q <= {lreq_q[1:0], learn_request_n};
    end
  end
  wire pclk_s    = pclk_q[1];
  wire pclk_rise = pclk_q[1] & ~pclk_q[2];
  wire pclk_fall = ~pclk_q[1] & pclk_q[2];
  wire lreq_fall = ~lreq_q[1] & lreq_q[2];

  // Millisecond tick; all programming timings are counted in these ticks.
  logic [31:0] div_q;
  wire         ms_tick = (div_q == 32'(MS_CYC - 1));
  always_ff @(posedge clk) begin
    if (!rst_n) div_q <= 32'h0;
    else div_q <= ms_tick ? 32'h0 : div_q + 32'h1;
  end

  // Programming entry, reception, checking and acknowledge.
  prog_e                st_q;
  logic [7:0]           up_ms_q;
  logic [7:0]           ph_ms_q;
  logic [6:0]           bit_q;
  logic [MSG_BITS-1:0]  msg_q;
  prov_s                nv_q;
  logic                 ack_q, ok_q, bad_q, erase_q;

  wire low_ok   = (ph_ms_q >= T_SETUP_MIN_MS) && (up_ms_q <= T_SETUP_MAX_MS);
  wire hold_ok  = (ph_ms_q >= T_HOLD_MIN_MS) && (ph_ms_q <= T_HOLD_MAX_MS);
  wire sum_ok   = (byte_sum(msg_q) == 8'h00);
  wire [7:0] up_n = (ms_tick && up_ms_q != 8'hFF) ? up_ms_q + 8'h1 : up_ms_q;
  wire [7:0] ph_n = (ms_tick && ph_ms_q != 8'hFF) ? ph_ms_q + 8'h1 : ph_ms_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q    <= P_POR;
      up_ms_q <= 8'h00;
      ph_ms_q <= 8'h00;
      bit_q   <= 7'h00;
      msg_q   <= '0;
      nv_q    <= '{man_key: MAN_KEY_RESET, cfg: CFG_RESET};
      ack_q   <= 1'b0;
      ok_q    <= 1'b0;
      bad_q   <= 1'b0;
      erase_q <= 1'b0;
    end else begin
      up_ms_q <= up_n;
      ph_ms_q <= ph_n;
      ok_q    <= 1'b0;
      bad_q   <= 1'b0;
      erase_q <= 1'b0;
      unique case (st_q)
        P_POR: begin
          // A clock line that never went low long enough, or rose late, means normal running.
          if (pclk_rise) begin
            st_q    <= low_ok ? P_HIGH : P_RUN;
            ph_ms_q <= 8'h00;
          end else if (pclk_s || up_ms_q > T_SETUP_MAX_MS) begin
            st_q    <= P_RUN;
          end
        end
        P_HIGH: begin
          if (pclk_fall) begin
            st_q  <= hold_ok ? P_RECV : P_RUN;
            bit_q <= 7'h00;
          end else if (ph_ms_q > T_HOLD_MAX_MS) begin
            st_q  <= P_RUN;
          end
        end
        P_RECV: begin
          // Bits enter at the top so byte 0 ends up in the lowest lane.
          if (pclk_rise) begin
            msg_q <= {pdat_q[1], msg_q[MSG_BITS-1:1]};
            bit_q <= bit_q + 7'h1;
            if (bit_q == BIT_LAST) st_q <= P_CHK;
          end
        end
        P_CHK: begin
          if (sum_ok) begin
            nv_q    <= '{man_key: msg_q[CFG_LSB-1:0], cfg: msg_q[CFG_LSB +: 8]};
            ack_q   <= 1'b1;
            ok_q    <= 1'b1;
            erase_q <= 1'b1;
            ph_ms_q <= 8'h00;
            st_q    <= P_ACK;
          end else begin
            bad_q   <= 1'b1;
            st_q    <= P_RUN;
          end
        end
        P_ACK: begin
          // Two ticks guarantee at least one full millisecond of acknowledge.
          if (ph_ms_q >= T_ACK_MS) begin
            ack_q <= 1'b0;
            st_q  <= P_RUN;
          end
        end
        P_RUN: begin
          st_q <= P_RUN;
        end
        default: st_q <= P_RUN;
      endcase
    end
  end

  // Key derivation inputs from the learn request.
  wire        secure  = nv_q.cfg[CFG_SEED_BIT];
  wire        use_xor = nv_q.cfg[CFG_SCHEME_BIT];
  wire [27:0] ser28   = learn_info.serial[27:0];
  seed_pair_s src_w;
  always_comb begin
    src_w = '{hi: {SRC_HI_NIBBLE, ser28}, lo: {SRC_LO_NIBBLE, ser28}};
    if (secure) begin
      unique case (learn_info.enc)
        ENC_SEED32: src_w = '{hi: {4'h0, ser28}, lo: learn_info.seed[31:0]};
        ENC_SEED48: src_w = '{hi: {4'h0, ser28[27:16], learn_info.seed[47:32]},
                              lo: learn_info.seed[31:0]};
        ENC_SEED60: src_w = '{hi: {4'h0, learn_info.seed[59:32]},
                              lo: learn_info.seed[31:0]};
        ENC_SERIAL28: src_w = '{hi: {SRC_HI_NIBBLE, ser28}, lo: {SRC_LO_NIBBLE, ser28}};
      endcase
    end
  end

  // Learn sequencer: derive, then store in a free slot or the rotating victim.
  learn_e                  ls_q;
  seed_pair_s              src_q;
  logic [31:0]             dec_q;
  logic [9:0]              rnd_q;
  logic [5:0]              kidx_q;
  logic [63:0]             key_q;
  logic [27:0]             slot_ser_q [NUM_SLOTS];
  logic [63:0]             slot_key_q [NUM_SLOTS];
  logic [NUM_SLOTS-1:0]    valid_q;
  logic [1:0]              victim_q;
  logic                    test_q, done_q, fail_q;

  wire        serial_zero = (learn_info.serial[27:0] == 28'h0);
  wire        dec_last    = (rnd_q == DEC_LAST_ROUND);
  wire [31:0] dec_n       = dec_round(dec_q, nv_q.man_key[kidx_q]);
  wire [1:0]  free_slot   = !valid_q[0] ? 2'd0 : !valid_q[1] ? 2'd1 :
                            !valid_q[2] ? 2'd2 : !valid_q[3] ? 2'd3 : victim_q;

  // The derivation works on a sampled copy, so the caller need hold learn_info one cycle only.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ls_q     <= L_IDLE;
      src_q    <= '0;
      dec_q    <= 32'h0;
      rnd_q    <= 10'h0;
      kidx_q   <= DEC_KEY_START;
      key_q    <= 64'h0;
      valid_q  <= '0;
      victim_q <= 2'd0;
      test_q   <= 1'b0;
      done_q   <= 1'b0;
      fail_q   <= 1'b0;
    end else begin
      victim_q <= victim_q + 2'd1;
      done_q   <= 1'b0;
      unique case (ls_q)
        L_IDLE: begin
          if (learn_req && serial_zero) begin
            done_q <= 1'b1;
            fail_q <= 1'b1;
          end else if (learn_req) begin
            src_q  <= src_w;
            dec_q  <= src_w.hi;
            rnd_q  <= 10'h0;
            kidx_q <= DEC_KEY_START;
            fail_q <= 1'b0;
            if (use_xor) begin
              key_q <= {src_w.hi ^ nv_q.man_key[63:32], src_w.lo ^ nv_q.man_key[31:0]};
              ls_q  <= L_STOR;
            end else begin
              ls_q  <= L_HI;
            end
          end
        end
        L_HI, L_LO: begin
          dec_q  <= dec_n;
          rnd_q  <= rnd_q + 10'h1;
          kidx_q <= kidx_q - 6'h1;
          if (dec_last && ls_q == L_HI) begin
            key_q[63:32] <= dec_n;
            dec_q        <= src_q.lo;
            rnd_q        <= 10'h0;
            kidx_q       <= DEC_KEY_START;
            ls_q         <= L_LO;
          end else if (dec_last) begin
            key_q[31:0]  <= dec_n;
            ls_q         <= L_STOR;
          end
        end
        L_STOR: begin
          valid_q[free_slot] <= 1'b1;
          test_q             <= 1'b0;
          done_q             <= 1'b1;
          ls_q               <= L_IDLE;
        end
        default: ls_q <= L_IDLE;
      endcase
      // Erase wins over a store landing in the same cycle.
      if (erase_q) begin
        valid_q <= '0;
        test_q  <= 1'b1;
      end
    end
  end

  // Slot contents carry no reset; validity bits alone decide what counts as learned.
  always_ff @(posedge clk) begin
    if (ls_q == L_STOR) begin
      slot_ser_q[free_slot] <= src_q.hi[27:0];
      slot_key_q[free_slot] <= key_q;
    end
  end

  // Success indicator: toggles for four seconds, a button press cuts it short.
  logic [11:0] ind_ms_q;
  logic [11:0] tog_ms_q;
  logic        ind_on_q, ind_q;
  wire         learned = (ls_q == L_STOR);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ind_ms_q <= 12'h0;
      tog_ms_q <= 12'h0;
      ind_on_q <= 1'b0;
      ind_q    <= 1'b0;
    end else if (learned) begin
      ind_on_q <= 1'b1;
      ind_ms_q <= 12'h0;
      tog_ms_q <= 12'h0;
      ind_q    <= 1'b1;
    end else if (ind_on_q && (lreq_fall || ind_ms_q >= T_LEARN_IND_MS)) begin
      ind_on_q <= 1'b0;
      ind_q    <= 1'b0;
    end else if (ind_on_q && ms_tick) begin
      ind_ms_q <= ind_ms_q + 12'h1;
      tog_ms_q <= (tog_ms_q == T_TOGGLE_MS - 12'h1) ? 12'h0 : tog_ms_q + 12'h1;
      if (tog_ms_q == T_TOGGLE_MS - 12'h1) ind_q <= ~ind_q;
    end
  end

  // Outputs from flip-flops; prog_mode decodes st_q and prog_data_oe_n inverts ack_q.
  assign prog_data_out        = ack_q;
  assign prog_data_oe_n       = ~ack_q;
  assign prog_mode            = (st_q == P_RECV);
  assign prog_ok              = ok_q;
  assign prog_bad             = bad_q;
  assign keygen_scheme_select = nv_q.cfg[CFG_SCHEME_BIT];
  assign seed_learn_enable    = nv_q.cfg[CFG_SEED_BIT];
  assign sleep_enable         = nv_q.cfg[CFG_SLEEP_BIT];
  assign learn_done           = done_q;
  assign learn_fail           = fail_q;
  assign learn_indicator      = ind_q;
  assign crypt_key            = key_q;
  assign slot_valid           = valid_q;
  assign test_tx_present      = test_q;

  // Checks kept beside the logic they guard.
  ack_needs_sum_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(ack_q) |-> $past(sum_ok) && $past(st_q) == P_CHK)
    else $error("Acknowledge without a good checksum.");
  bad_sum_keeps_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == P_CHK && !sum_ok) |=> $stable(nv_q) && !ack_q)
    else $error("Bad checksum changed storage or acknowledged.");
  store_then_erase_a: assert property (@(posedge clk) disable iff (!rst_n)
    ok_q |=> valid_q == '0 && test_q)
    else $error("Programming did not erase all slots.");
  erase_test_tx_a: assert property (@(posedge clk) disable iff (!rst_n)
    erase_q |=> test_q)
    else $error("Erase did not install the test transmitter.");
  learn_clears_test_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ls_q == L_STOR && !erase_q) |=> !test_q && valid_q != '0)
    else $error("Learning kept the test transmitter.");
  zero_serial_fail_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ls_q == L_IDLE && learn_req && serial_zero) |=> done_q && fail_q && ls_q == L_IDLE)
    else $error("Serial zero was not refused.");
  xor_key_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ls_q == L_IDLE && learn_req && !serial_zero && use_xor)
      |=> key_q == {src_q.hi ^ nv_q.man_key[63:32], src_q.lo ^ nv_q.man_key[31:0]})
    else $error("XOR key derivation mismatch.");
  cut_indicator_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ind_on_q && lreq_fall && !learned) |=> !ind_on_q ##1 !ind_q)
    else $error("Learn press did not stop the indicator.");
  hold_window_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == P_HIGH && pclk_fall) |=> (st_q == P_RECV) == $past(hold_ok))
    else $error("Programming entry ignored the hold window.");
  recv_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == P_RECV && pclk_rise && bit_q == BIT_LAST) |=> st_q == P_CHK)
    else $error("Message length is not eighty bits.");

endmodule // rke_provision_keygen
`default_nettype wire

// ---- test/rke_programmer.sv ----
// Behavioural model of the production programmer on the clock and data pins.
// Assumes the bench resolves the data wire and that a pull-up holds it high when released.
`timescale 1ns/1ps
`default_nettype none
module rke_programmer #(
  parameter int MS_CYC = 20                 // Device clock cycles per millisecond tick.
) (
  output logic pclk,                        // Programming clock pin.
  output logic pdata,                       // Data level while driving.
  output logic pdrive                       // High while the model drives data.
);
  localparam int MS_NS = MS_CYC * 10;

  // The clock stands low from power-up so that the device sees a legal entry.
  initial begin
    pclk = 1'b0;
    pdata = 1'b0;
    pdrive = 1'b0;
  end

  // Low for three ticks after release, then high for twenty ticks, then low again.
  task automatic enter();
    #(3 * MS_NS);
    pclk = 1'b1;
    #(20 * MS_NS);
    pclk = 1'b0;
    #(MS_NS);
  endtask

  // Bit 0 leads; data settles half a period before each rising edge.
  task automatic send(input logic [79:0] msg);
    pdrive = 1'b1;
    for (int i = 0; i < 80; i++) begin
      pdata = msg[i];
      #62.5 pclk = 1'b1;
      #62.5 pclk = 1'b0;
    end
    pdrive = 1'b0;
  endtask
endmodule // rke_programmer
`default_nettype wire

// ---- test/rke_provision_keygen_test.sv ----
// Self-checking bench for the provisioning loader and key derivation.
// Assumes the programmer model in its own file and a pull-up on the data wire.
`timescale 1ns/1ps
`default_nettype none
module rke_provision_keygen_test
  import rke_prov_pkg::*;
;
  // Five cycles per tick keeps the four-second indication within the cycle budget.
  localparam int MS = 5;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        learn_req = 1'b0;
  logic        learn_request_n = 1'b1;
  learn_req_s  learn_info = '0;
  logic        pclk, pdata, pdrive, dout, oe_n, pok, pbad, sch, sle, slp, ldone, lfail, lind, ttx;
  logic [63:0] ckey;
  logic [3:0]  slots;
  logic [63:0] mk = '0;
  logic [7:0]  cfg = '0;
  logic [64:0] ln;
  logic [3:0]  pq[$];
  logic [64:0] lq[$];
  int          error_cnt = 0;
  int          n_checks = 0;
  wire         data_pin;

  // The device wins the wire while it drives; otherwise the programmer, and with neither the pull-up shows through.
  assign data_pin = !oe_n ? dout : (pdrive ? pdata : 1'b1);

  always #5 clk = ~clk;

  rke_programmer #(.MS_CYC(MS)) prog_u (.pclk(pclk), .pdata(pdata), .pdrive(pdrive));

  rke_provision_keygen #(.MS_CYC(MS)) dut_u (
    .clk(clk), .rst_n(rst_n), .prog_clk_in(pclk), .prog_data_in(data_pin), .prog_data_out(dout),
    .prog_data_oe_n(oe_n), .prog_mode(), .prog_ok(pok), .prog_bad(pbad), .keygen_scheme_select(sch),
    .seed_learn_enable(sle), .sleep_enable(slp), .learn_req(learn_req), .learn_info(learn_info),
    .learn_request_n(learn_request_n), .learn_done(ldone), .learn_fail(lfail), .learn_indicator(lind),
    .crypt_key(ckey), .slot_valid(slots), .test_tx_present(ttx));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] dec_ref(input logic [31:0] x);
    logic [31:0] y;
    y = x;
    for (int i = 0; i < 528; i++) y = {y[30:0], y[31] ^ y[15] ^ mk[(15 - i) & 63]
      ^ NLF_TABLE[{y[30], y[25], y[19], y[8], y[0]}]};
    return y;
  endfunction

  function automatic logic [63:0] key_ref(input learn_req_s r);
    logic [31:0] h;
    logic [31:0] l;
    h = {SRC_HI_NIBBLE, r.serial[27:0]};
    l = {SRC_LO_NIBBLE, r.serial[27:0]};
    if (cfg[2] && r.enc != ENC_SERIAL28) begin
      l = r.seed[31:0];
      case (r.enc)
        ENC_SEED32: h = {4'h0, r.serial[27:0]};
        ENC_SEED48: h = {4'h0, r.serial[27:16], r.seed[47:32]};
        default: h = {4'h0, r.seed[59:32]};
      endcase
    end
    if (cfg[0]) return {h ^ mk[63:32], l ^ mk[31:0]};
    return {dec_ref(h), dec_ref(l)};
  endfunction

  function automatic learn_req_s rnd_req(input enc_type_e e);
    learn_req_s r;
    r.enc = e;
    r.serial = $urandom;
    r.serial[0] = 1'b1; // A zero serial is only ever chosen on purpose.
    r.seed = 60'({$urandom, $urandom});
    return r;
  endfunction

  task automatic rst();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    mk = '0;
    cfg = '0;
  endtask

  // Entry starts right at release, which is the device's power-up.
  task automatic load_msg(input logic [63:0] k, input logic [7:0] c, input logic bad);
    logic [7:0] s;
    s = c;
    for (int i = 0; i < 8; i++) s += k[8 * i +: 8];
    s = 8'h00 - s + {7'h0, bad};
    pq.push_back(bad ? 4'h6 : 4'h9);
    #1 prog_u.enter();
    prog_u.send({s, c, k});
    for (int i = 0; i < 100 && pok !== 1'b1 && pbad !== 1'b1; i++) @(negedge clk);
    if (!bad) begin
      mk = k;
      cfg = c;
    end
  endtask

  task automatic learn(input learn_req_s r);
    lq.push_back({r.serial[27:0] == 28'h0, key_ref(r)});
    @(posedge clk);
    learn_info <= r;
    learn_req <= 1'b1;
    @(posedge clk);
    learn_req <= 1'b0;
    for (int i = 0; i < 1200 && ldone !== 1'b1; i++) @(negedge clk);
  endtask

  // Results are matched in order of request, whenever the device reports one.
  always @(negedge clk) begin
    if (pok === 1'b1 || pbad === 1'b1) chk({pok, pbad, oe_n, dout}, pq.size() ? pq.pop_front() : 4'hX);
    if (ldone === 1'b1) begin
      ln = lq.size() ? lq.pop_front() : {65{1'bx}};
      chk(lfail, ln[64]);
      if (ln[64] === 1'b0) chk(ckey, ln[63:0]);
    end
  end

  // Main sequence: a refused message, then a stored one followed by learning.
  initial begin
    learn_req_s r;
    void'($urandom(6333));
    rst();
    load_msg({$urandom, $urandom}, 8'h0D, 1'b1);
    chk({sch, sle, slp, ttx}, 4'h0);
    learn(rnd_req(ENC_SERIAL28));
    rst();
    load_msg({$urandom, $urandom}, (8'($urandom) & 8'hF2) | 8'h0D, 1'b0);
    chk({sch, sle, slp}, 3'h7);
    @(negedge clk);
    chk({slots, ttx}, 5'h01);
    repeat (80) @(negedge clk);
    chk({oe_n, dout}, 2'h2);
    r = rnd_req(ENC_SERIAL28);
    r.serial[27:0] = 28'h0;
    learn(r);
    for (int e = 0; e < 4; e++) begin
      learn(rnd_req(enc_type_e'(e)));
      chk({ttx, lind}, 2'h1);
    end
    chk(slots, 4'hF);
    repeat (20100) @(negedge clk);
    chk(lind, 1'b0);
    learn(rnd_req(ENC_SEED60));
    @(posedge clk);
    learn_request_n <= 1'b0;
    repeat (3) @(posedge clk);
    learn_request_n <= 1'b1;
    repeat (8) @(negedge clk);
    chk(lind, 1'b0);
    chk(pq.size() + lq.size(), 0);
    complete_run();
  end

  // The whole run needs roughly 250 us; well beyond that means a hang.
  initial begin
    #600000;
    error_cnt++;
    complete_run();
  end
endmodule // rke_provision_keygen_test
`default_nettype wire
